/* logic/iop_pkg.sv */
// Purpose: Shared constants and frame carriers for the I/O port command handler.
// Assumes: Nine-byte command and reply frames, values sent most significant byte first.
// Notes: The status codes other than OK are a local choice.
package iop_pkg;
  localparam logic [7:0] INSTR_SET_OUTPUT = 8'h0e;
  localparam logic [7:0] INSTR_GET_INPUT = 8'h0f;
  localparam logic [7:0] BANK_DIGITAL_IN = 8'h00;
  localparam logic [7:0] BANK_ANALOG_IN = 8'h01;
  localparam logic [7:0] BANK_DIGITAL_OUT = 8'h02;
  localparam logic [7:0] PORT_ALL = 8'hff;
  localparam logic [7:0] PORT_ENABLE = 8'h0a;
  localparam logic [31:0] VALUE_FROM_ACCU = 32'hffffffff;
  localparam logic [7:0] STATUS_OK = 8'h64;
  localparam logic [7:0] STATUS_BAD_CHECKSUM = 8'h01;
  localparam logic [7:0] STATUS_BAD_INSTR = 8'h02;
  localparam logic [7:0] STATUS_BAD_VALUE = 8'h04;
  localparam logic [3:0] FRAME_BYTES = 4'd9;
  localparam logic [3:0] OUTPUTS_RESET = 4'h0;
  localparam logic [31:0] ACCU_RESET = 32'h00000000;

  // One decoded command frame
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] instr;
    logic [7:0] kind;
    logic [7:0] bank;
    logic [31:0] value;
  } iop_cmd_s;

  // One reply before its checksum
  typedef struct packed {
    logic [7:0] host;
    logic [7:0] addr;
    logic [7:0] status;
    logic [7:0] instr;
    logic [31:0] value;
  } iop_reply_s;
endpackage : iop_pkg

/* logic/iop_port_handler.sv */
// Purpose: Executes set-output and get-input commands taken from a byte stream and sends replies.
// Assumes: Command bytes arrive from logic on core_clk; inputs and enable come from pins.
// Notes: In standalone mode no reply is sent, the result goes to the accumulator.
// Notes: Frames for other module addresses are ignored without any reply.
// Notes: The enable pin reads as not enabled until it has been sampled twice.
//
// What this block does
// - Instruction 14, bank 2 drives the addressed output to value 0 or 1.
// - Four settable outputs in bank 2, ports 0 to 3, values 0 or 1.
// - Set-output port 255 bank 2 writes all four outputs from value bits.
// - Set-all with value -1 takes the bit vector from the accumulator.
// - Instruction 15 reads the line chosen by type in bank 0, 1 or 2.
// - Digital reads of one port give 0 or 1, port 255 gives a 4-bit vector; analog reads give 16-bit unsigned values.
// - Standalone mode loads the get-input result into the accumulator.
// - Direct mode replies with the result and leaves the accumulator alone unless the read is port 255 in bank 0.
// - A good get-input read replies status 100 with the value.
// - Bank 0 ports 0 to 3 return the four input levels.
// - Get-input port 255 bank 0 puts all inputs into the accumulator as bits.
// - Inputs read as digital in bank 0 and analog in bank 1 together.
// - Bank 2 ports 0 to 3 read back the output levels last set.
// - Get-input port 10 bank 0 returns 0 when enabled, 1 otherwise.
//
// Frame timing, in core_clk edges with clk_en high:
//   edge E     takes the ninth command byte and moves to execution
//   edge E+1   updates the outputs and the accumulator, pulses accu_load
//   edge E+2   shows the first reply byte; eight more follow back to back
// Bytes that arrive while a command executes or a reply is sent are dropped
// without any sign, so the host must wait for the whole reply first.
// There is no timeout on a partial frame: a lost byte shifts every later
// frame until the host resynchronises, which it sees as checksum errors.
//
// Refusals:
//   a frame for another module address is ignored entirely, no reply
//   a bad checksum gives status 01h and changes nothing
//   an unknown instruction, or set-output outside bank 2, gives status 02h
//   a bad port, bank or value gives status 04h and changes nothing
//
// Accumulator:
//   get-input with port 255 in bank 0 loads it in both modes
//   any other good get-input loads it only in standalone mode
//   set-output with port 255 and value -1 reads its low four bits
//
// Reply layout, first byte on the wire first:
//   host address, module address, status, instruction echo,
//   value bits 31:24, 23:16, 15:8, 7:0, checksum
// The reply checksum is the eight-bit sum of the eight bytes before it.
// The value is the read result for a good get-input and zero otherwise.
//
// Pins:
//   general_input and enable_pin_n pass two flops, so a pin change shows
//   in reads two enabled edges later; the converter words are on core_clk
//   and are read as they stand.
//   The enable synchroniser resets to 1, so the block reads as disabled
//   until the pin has been sampled twice.
`timescale 1ns/1ns
module iop_port_handler #(
  parameter logic [7:0] MODULE_ADDR = 8'h01,
  parameter logic [7:0] HOST_ADDR = 8'h02
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Command byte stream
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  // Mode and accumulator link
  input wire logic standalone,
  output logic [31:0] accu,
  output logic accu_load,
  // Reply byte stream
  output logic reply_valid,
  output logic [7:0] reply_byte,
  // Pins and converter results
  input wire logic [3:0] general_input,
  input wire logic enable_pin_n,
  input wire logic [63:0] adc_values,
  output logic [3:0] digital_output
);
  import iop_pkg::*;

  // Sequencer states, Gray coded along collect, execute, reply
  typedef enum logic [1:0] {
    ST_COLLECT = 2'b00, // Shifting in command bytes
    ST_EXEC = 2'b01, // One cycle to decode and act
    ST_REPLY = 2'b11 // Nine reply bytes back to back
  } iop_state_e;

  // Byte of a packed frame, index 0 first on the wire
  function automatic logic [7:0] frame_byte(input logic [71:0] frame, input logic [3:0] idx);
    frame_byte = frame[8'(71 - 8 * idx) -: 8];
  endfunction : frame_byte

  // Ports 0 to 3 address one of the four lines in every bank
  function automatic logic is_line_port(input logic [7:0] kind);
    is_line_port = (kind < 8'h04);
  endfunction : is_line_port

  // Frame sequencer state
  iop_state_e state, next_state;
  logic [3:0] count, next_count;

  // Receive shift register and running sum
  logic [71:0] rx, next_rx;
  logic [7:0] sum, next_sum;

  // Reply frame held while it is sent
  logic [71:0] tx, next_tx;

  // Output, accumulator and reply next values
  logic [3:0] next_digital_output;
  logic [31:0] next_accu;
  logic next_accu_load, next_reply_valid;
  logic [7:0] next_reply_byte;

  // Synchroniser stages
  logic [3:0] in_s1, in_s2;
  logic en_s1, en_s2;
  logic [3:0] next_in_s1, next_in_s2;
  logic next_en_s1, next_en_s2;

  // Decoded command and its outcome
  iop_cmd_s cmd;
  iop_reply_s rep;
  logic [7:0] status;
  logic [31:0] result;
  logic [7:0] rsum;
  logic send;

  // Next synchroniser stages; nothing but the second stage reads the first
  always_comb begin
    next_in_s1 = general_input;
    next_in_s2 = in_s1;
    next_en_s1 = enable_pin_n;
    next_en_s2 = en_s1;
  end

  // Pins pass two flops before use
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_s1 <= 4'h0;
      in_s2 <= 4'h0;
      en_s1 <= 1'b1;
      en_s2 <= 1'b1;
    end else if (clk_en) begin
      in_s1 <= next_in_s1;
      in_s2 <= next_in_s2;
      en_s1 <= next_en_s1;
      en_s2 <= next_en_s2;
    end
  end

  assign cmd = iop_cmd_s'(rx[71:8]);

  // Execute decoded command; value is read fresh so banks 0 and 1 see the same lines
  always_comb begin
    status = STATUS_OK;
    result = 32'h00000000;
    next_digital_output = digital_output;
    // A bad checksum blocks every action
    if (rx[7:0] != sum) begin
      status = STATUS_BAD_CHECKSUM;
    // Set-output acts only on bank 2
    end else if (cmd.instr == INSTR_SET_OUTPUT && cmd.bank == BANK_DIGITAL_OUT) begin
      if (cmd.kind == PORT_ALL) begin
        if (cmd.value == VALUE_FROM_ACCU) begin
          next_digital_output = accu[3:0];
        end else begin
          next_digital_output = cmd.value[3:0];
        end
      end else if (is_line_port(cmd.kind) && cmd.value < 32'h00000002) begin
        next_digital_output[cmd.kind[1:0]] = cmd.value[0];
      end else begin
        status = STATUS_BAD_VALUE;
      end
    // Reads change nothing here; the sequencer loads the accumulator
    end else if (cmd.instr == INSTR_GET_INPUT) begin
      if (cmd.bank == BANK_DIGITAL_IN && is_line_port(cmd.kind)) begin
        result = {31'h0, in_s2[cmd.kind[1:0]]};
      end else if (cmd.bank == BANK_DIGITAL_IN && cmd.kind == PORT_ALL) begin
        result = {28'h0, in_s2};
      end else if (cmd.bank == BANK_DIGITAL_IN && cmd.kind == PORT_ENABLE) begin
        result = {31'h0, en_s2};
      end else if (cmd.bank == BANK_ANALOG_IN && is_line_port(cmd.kind)) begin
        result = {16'h0, adc_values[{cmd.kind[1:0], 4'h0} +: 16]};
      end else if (cmd.bank == BANK_DIGITAL_OUT && is_line_port(cmd.kind)) begin
        result = {31'h0, digital_output[cmd.kind[1:0]]};
      end else begin
        status = STATUS_BAD_VALUE;
      end
    // Anything else is not an instruction this block handles
    end else begin
      status = STATUS_BAD_INSTR;
    end
    // Only an executing frame for this module may move the outputs
    if (state != ST_EXEC || cmd.addr != MODULE_ADDR) begin
      next_digital_output = digital_output;
    end
  end

  // Reply payload and its checksum
  // The value is zeroed for set-output and refused frames, so a host
  // never sees stale read data in a reply that carries no read
  always_comb begin
    rep.host = HOST_ADDR;
    rep.addr = MODULE_ADDR;
    rep.status = status;
    rep.instr = cmd.instr;
    rep.value = (status == STATUS_OK && cmd.instr == INSTR_GET_INPUT) ? result : 32'h00000000;
    rsum = 8'h00;
    for (int i = 0; i < 8; i++) begin
      rsum = rsum + frame_byte({rep, 8'h00}, 4'(i));
    end
  end

  // Frame sequencer; standalone commands give no reply
  always_comb begin
    next_state = state;
    next_count = count;
    next_rx = rx;
    next_sum = sum;
    next_tx = tx;
    next_accu = accu;
    next_accu_load = 1'b0;
    next_reply_valid = 1'b0;
    next_reply_byte = reply_byte;
    send = 1'b0;
    unique case (state)
      ST_COLLECT: begin
        // The checksum byte itself is not summed
        if (cmd_valid) begin
          next_rx = {rx[63:0], cmd_byte};
          next_count = count + 4'd1;
          if (count != FRAME_BYTES - 4'd1) begin
            next_sum = sum + cmd_byte;
          end else begin
            next_state = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        // A frame for another address falls back to collecting, no reply
        next_count = 4'd0;
        next_sum = 8'h00;
        send = (cmd.addr == MODULE_ADDR);
        if (send && status == STATUS_OK && cmd.instr == INSTR_GET_INPUT && standalone) begin
          next_accu = result;
          next_accu_load = 1'b1;
        end else if (send && status == STATUS_OK && cmd.instr == INSTR_GET_INPUT
                     && cmd.bank == BANK_DIGITAL_IN && cmd.kind == PORT_ALL) begin
          next_accu = result;
          next_accu_load = 1'b1;
        end
        // Direct mode otherwise keeps the accumulator
        next_tx = {rep, rsum};
        next_state = (send && !standalone) ? ST_REPLY : ST_COLLECT;
      end
      ST_REPLY: begin
        // count walks the nine reply bytes, then the sequencer idles
        next_reply_valid = 1'b1;
        next_reply_byte = frame_byte(tx, count);
        next_count = count + 4'd1;
        if (count == FRAME_BYTES - 4'd1) begin
          next_count = 4'd0;
          next_state = ST_COLLECT;
        end
      end
      default: next_state = ST_COLLECT;
    endcase
  end

  // Register sequencer, frame, accumulator and reply state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_COLLECT;
      count <= 4'd0;
      rx <= 72'h0;
      sum <= 8'h00;
      tx <= 72'h0;
      accu <= ACCU_RESET;
      accu_load <= 1'b0;
      reply_valid <= 1'b0;
      reply_byte <= 8'h00;
    end else if (clk_en) begin
      state <= next_state;
      count <= next_count;
      rx <= next_rx;
      sum <= next_sum;
      tx <= next_tx;
      accu <= next_accu;
      accu_load <= next_accu_load;
      reply_valid <= next_reply_valid;
      reply_byte <= next_reply_byte;
    end
  end

  // Output levels, gated in the execute logic
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      digital_output <= OUTPUTS_RESET;
    end else if (clk_en) begin
      digital_output <= next_digital_output;
    end
  end
endmodule : iop_port_handler

/* tb/iop_host_model.sv */
// Purpose: Host side model that sends command frames and collects replies.
// Assumes: Frames are sent one at a time, with the next only after the reply.
// Notes: Between frames the byte lines show the inverse of the last byte.
`timescale 1ns/1ns
module iop_host_model (
  // Clock
  input wire logic core_clk,
  // Command stream
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  // Reply stream
  input wire logic reply_valid,
  input wire logic [7:0] reply_byte
);
  import iop_pkg::*;
  logic [71:0] rx;
  int rx_n = 0;
  initial begin
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
  end
  // Nine bytes, value MSB first, checksum is the low byte of the sum
  task automatic send(input iop_cmd_s c);
    logic [7:0] b [9];
    b[8] = 8'h00;
    for (int i = 0; i < 8; i++) begin
      b[i] = c[63-8*i -: 8];
      b[8] += b[i];
    end
    for (int i = 0; i < 9; i++) begin
      @(posedge core_clk);
      cmd_valid <= 1'b1;
      cmd_byte <= b[i];
    end
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    cmd_byte <= ~b[8];
  endtask : send
  // Shift reply bytes in, oldest at the top
  always @(posedge core_clk) begin
    if (reply_valid) begin
      rx <= {rx[63:0], reply_byte};
      rx_n <= rx_n + 1;
    end
  end
endmodule : iop_host_model

/* tb/iop_port_handler_asserts.sv */
// Purpose: Port checks on the I/O port handler.
// Assumes: One clock, reset active low.
// Notes: Bound to every handler instance.
`timescale 1ns/1ns
module iop_port_handler_asserts #(
  parameter logic [7:0] MODULE_ADDR = 8'h01,
  parameter logic [7:0] HOST_ADDR = 8'h02
) (
  // Watched ports
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic standalone,
  input wire logic [31:0] accu,
  input wire logic accu_load,
  input wire logic reply_valid,
  input wire logic [7:0] reply_byte,
  input wire logic [3:0] digital_output
);
  logic [7:0] sum;
  logic [7:0] next_sum;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Sum of the reply so far, so the last byte can be judged
  always_comb next_sum = reply_valid ? sum + reply_byte : 8'h00;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) sum <= 8'h00;
    else sum <= next_sum;
  end
  a_reply_len: assert property ($rose(reply_valid) |-> reply_valid[*8] ##1 reply_valid ##1 !reply_valid)
    else $error("reply length wrong");
  a_reply_head: assert property ($rose(reply_valid) |-> reply_byte == HOST_ADDR ##1 reply_byte == MODULE_ADDR)
    else $error("reply head wrong");
  a_reply_status: assert property ($rose(reply_valid) |-> ##2 reply_byte inside {8'h64, 8'h01, 8'h02, 8'h04})
    else $error("reply status wrong");
  a_reply_sum: assert property ($rose(reply_valid) ##8 reply_valid |-> reply_byte == sum)
    else $error("reply checksum wrong");
  a_load_pulse: assert property (accu_load |=> !accu_load)
    else $error("load pulse too long");
  a_accu_cause: assert property ($changed(accu) |-> accu_load)
    else $error("accu changed unloaded");
  a_out_reply: assert property ($changed(digital_output) && !standalone |=> $rose(reply_valid))
    else $error("outputs moved without reply");
  a_mode_quiet: assert property ($rose(reply_valid) |-> !$past(standalone))
    else $error("reply in standalone");
endmodule : iop_port_handler_asserts
bind iop_port_handler iop_port_handler_asserts #(.MODULE_ADDR(MODULE_ADDR), .HOST_ADDR(HOST_ADDR))
  iop_port_handler_asserts_i (.core_clk(core_clk), .rst_n(rst_n), .standalone(standalone), .accu(accu),
  .accu_load(accu_load), .reply_valid(reply_valid), .reply_byte(reply_byte), .digital_output(digital_output));

/* tb/iop_port_handler_test.sv */
// Purpose: Self-checking bench for the I/O port handler.
// Assumes: Default addresses, clk_en held high.
// Notes: Replies are judged 12 cycles after the last byte.
`timescale 1ns/1ns
module iop_port_handler_test;
  import iop_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic standalone = 1'b0;
  logic [3:0] general_input = 4'h9;
  logic enable_pin_n = 1'b1;
  logic [63:0] adc_values = 64'hffff_8000_012e_0001;
  logic cmd_valid, accu_load, reply_valid;
  logic [7:0] cmd_byte, reply_byte;
  logic [31:0] accu;
  logic [3:0] digital_output;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  int loads = 0;
  always #20 core_clk = ~core_clk;
  // Count accumulator load pulses
  always @(posedge core_clk) if (accu_load === 1'b1) loads++;
  iop_port_handler iop_port_handler_i (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .standalone(standalone), .accu(accu), .accu_load(accu_load), .reply_valid(reply_valid),
    .reply_byte(reply_byte), .general_input(general_input), .enable_pin_n(enable_pin_n),
    .adc_values(adc_values), .digital_output(digital_output));
  iop_host_model iop_host_model_i (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .reply_valid(reply_valid), .reply_byte(reply_byte));
  task automatic chk(input string what, input logic [71:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // One command, then the whole reply or its absence is judged
  task automatic op(input logic [7:0] ins, k, bk, st, input logic [31:0] v, rv);
    logic [63:0] e;
    logic [7:0] s;
    int n;
    e = {8'h02, 8'h01, st, ins, rv};
    s = 8'h00;
    for (int i = 0; i < 8; i++) s += e[63-8*i -: 8];
    n = iop_host_model_i.rx_n;
    iop_host_model_i.send({8'h01, ins, k, bk, v});
    repeat (12) @(posedge core_clk);
    chk("count", 72'(iop_host_model_i.rx_n - n), standalone ? 72'd0 : 72'd9);
    if (!standalone) chk("reply", iop_host_model_i.rx, {e, s});
  endtask : op
  task automatic t_set;
    for (int p = 0; p < 4; p++) begin
      op(8'h0e, 8'(p), 8'h02, 8'h64, 32'h1, 32'h0);
      chk("outputs", 72'(digital_output), 72'((2 << p) - 1));
    end
    op(8'h0e, 8'hff, 8'h02, 8'h64, 32'h6, 32'h0);
    chk("outputs", 72'(digital_output), 72'h6);
    for (int p = 0; p < 4; p++) op(8'h0f, 8'(p), 8'h02, 8'h64, 32'h0, 32'((6 >> p) & 1));
    $display("t_set done");
  endtask : t_set
  task automatic t_in;
    for (int p = 0; p < 4; p++) begin
      op(8'h0f, 8'(p), 8'h00, 8'h64, 32'h0, 32'(general_input[p]));
      op(8'h0f, 8'(p), 8'h01, 8'h64, 32'h0, 32'(adc_values[16*p +: 16]));
    end
    for (int e = 1; e >= 0; e--) begin
      enable_pin_n <= e[0];
      repeat (4) @(posedge core_clk);
      op(8'h0f, 8'h0a, 8'h00, 8'h64, 32'h0, 32'(e));
    end
    op(8'h0f, 8'h00, 8'h03, 8'h04, 32'h0, 32'h0);
    chk("accu", 72'(accu), 72'h0);
    $display("t_in done");
  endtask : t_in
  task automatic t_accu;
    op(8'h0f, 8'hff, 8'h00, 8'h64, 32'h0, 32'h9);
    chk("accu", 72'(accu), 72'h9);
    op(8'h0e, 8'hff, 8'h02, 8'h64, 32'hffffffff, 32'h0);
    chk("outputs", 72'(digital_output), 72'h9);
    op(8'h0f, 8'h00, 8'h01, 8'h64, 32'h0, 32'h1);
    chk("accu", 72'(accu), 72'h9);
    op(8'h13, 8'h00, 8'h00, 8'h02, 32'h0, 32'h0);
    standalone <= 1'b1;
    @(posedge core_clk);
    op(8'h0f, 8'h02, 8'h01, 8'h64, 32'h0, 32'h0);
    chk("accu", 72'(accu), 72'h8000);
    chk("loads", 72'(loads), 72'd2);
    standalone <= 1'b0;
    $display("t_accu done");
  endtask : t_accu
  task automatic results;
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  // Main sequence after a 12-cycle reset
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_set();
    t_in();
    t_accu();
    results();
  end
  // Hang guard, well above the ~600 cycles the tests need
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      results();
    end
  end
endmodule : iop_port_handler_test
